// file: rtl/mbi_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sixty-four program words hold thirty-two vectors
// - separate program and data bus sets
// - qualifiers mark each read or write kind
// - 16-bit, 32-bit and byte accesses supported
// - byte strobes name the transferred byte
// - 22-bit program address for reads and writes
// - 32-bit data-read address, reads only
// - 32-bit data-write address, writes only
// - 32-bit program read data returns instructions
// - 32-bit data read data returns data
// - one 32-bit write bus for both writes
// - never program read and write together
// - never program write and data write together
// - disjoint buses run in the same cycle
// - odd 32-bit access starts one lower
// - emitted address stays unaligned as generated
// - fetch 32-bit, instruction boundaries found internally
// - each location is one 16-bit word
module mbi_core_if
  import mbi_pkg::*;
#(
  parameter logic [PAW-1:0] VEC_BASE = VEC_BASE_DEF
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_reset,
  // core side: fetch request
  input  wire logic            i_fetch_req,
  input  wire logic [PAW-1:0]  i_fetch_addr,
  output logic                 o_fetch_ready,
  output logic [DW-1:0]        o_fetch_data,
  output logic                 o_fetch_valid,
  // core side: data read request
  input  wire logic            i_rd_req,
  input  wire logic [DAW-1:0]  i_rd_addr,
  input  wire logic [1:0]      i_rd_size,
  output logic [DW-1:0]        o_rd_data,
  output logic                 o_rd_valid,
  // core side: write request, program or data space
  input  wire logic            i_wr_req,
  input  wire logic            i_wr_prog,
  input  wire logic [DAW-1:0]  i_wr_addr,
  input  wire logic [1:0]      i_wr_size,
  input  wire logic [DW-1:0]   i_wr_data,
  output logic                 o_wr_ready,
  // core side: vector fetch
  input  wire logic [4:0]      i_vec_num,
  output logic [PAW-1:0]       o_vec_addr,
  // memory side: program buses
  output logic [PAW-1:0]       o_prog_addr_bus,
  output logic                 o_prog_rd,
  output logic                 o_prog_wr,
  output logic                 o_prog_is32,
  input  wire logic [DW-1:0]   i_prog_rd_data_bus,
  // memory side: data read buses
  output logic [DAW-1:0]       o_data_rd_addr_bus,
  output logic                 o_data_rd,
  output logic                 o_data_rd_is32,
  output logic [1:0]           o_data_rd_strobe,
  input  wire logic [DW-1:0]   i_data_rd_data_bus,
  // memory side: data write buses
  output logic [DAW-1:0]       o_data_wr_addr_bus,
  output logic                 o_data_wr,
  output logic                 o_data_wr_is32,
  output logic [1:0]           o_wr_strobe,
  output logic [DW-1:0]        o_shared_wr_data_bus
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: refuse parameter values the logic cannot serve
  // a vector base on a two-word boundary keeps every vector pair inside
  // one aligned 32-bit fetch, so a vector never straddles two beats
  if (VEC_BASE[0] != 1'b0) begin : g_base_odd
    $error("vector base must be even");
  end

  // the whole vector table must fit below the top of program space,
  // otherwise the last vectors would wrap onto low program words
  if ((VEC_BASE + VEC_TABLE_SIZE) > (2 ** PAW)) begin : g_base_high
    $error("vector table runs past program space");
  end

  // the vector number port selects every entry and no more
  if (VEC_COUNT != (2 ** $bits(i_vec_num))) begin : g_vec_count
    $error("vector count does not match the vector number port");
  end

  // the vector address function doubles the number: two words per entry
  if (VEC_WORDS != 2) begin : g_vec_words
    $error("vector entries must be two words long");
  end

  // program write addresses are cut from the low bits of the write address
  if (PAW > DAW) begin : g_addr_width
    $error("program address wider than data address");
  end

  // one data bus beat carries exactly two addressable words
  if (DW != 2 * WW) begin : g_beat_width
    $error("data bus must carry two words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector table address: two words per vector
  // combinational so the core can start the vector fetch in the same
  // cycle it learns the vector number; no register sits on this path
  function automatic logic [PAW-1:0] vec_addr(input logic [4:0] n);
    vec_addr = VEC_BASE + PAW'({n, 1'b0});
  endfunction : vec_addr

  assign o_vec_addr = vec_addr(i_vec_num);

  ////////////////////////////////////////////////////////////////////////////
  // write arbitration: a program write waits for a program read in the
  // same cycle; the write is held and issued in the first cycle without a fetch request
  // hazard: a program read and a program write would both need the
  // program address bus, and a program write and a data write would both
  // need the shared write data bus; only one write is presented per cycle
  // so the second conflict cannot arise, and the first is resolved here
  // the requester must keep its write request up while ready is low
  mbi_wst_t         wst_r;
  logic             wr_go;
  logic             prog_wr_go;
  logic             data_wr_go;
  logic             fetch_go;

  // fetch owns the program bus first since it is older in program order
  assign fetch_go   = i_fetch_req;
  assign wr_go      = i_wr_req && !(i_wr_prog && fetch_go);
  assign prog_wr_go = wr_go && i_wr_prog;
  assign data_wr_go = wr_go && !i_wr_prog;
  assign o_wr_ready    = wr_go;
  assign o_fetch_ready = 1'b1;

  // tracks a stalled program write
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wst_r <= MBI_WR_IDLE;
    end else begin
      case (wst_r)
        MBI_WR_IDLE: if (i_wr_req && !wr_go) wst_r <= MBI_WR_HOLD;
        MBI_WR_HOLD: if (wr_go || !i_wr_req) wst_r <= MBI_WR_IDLE;
        default:     wst_r <= MBI_WR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte lane decode
  // one decoder per bus that can carry a byte access; the strobes are
  // forced to none when the bus is idle so external decode never sees a
  // stale lane select between transfers
  logic [1:0] rd_strb;
  logic       rd_is32;
  logic [1:0] wr_strb;
  logic       wr_is32;

  mbi_strobe u_rd_strb (
    .i_size   (i_rd_size),
    .i_valid  (i_rd_req),
    .o_strobe (rd_strb),
    .o_is32   (rd_is32)
  );

  mbi_strobe u_wr_strb (
    .i_size   (i_wr_size),
    .i_valid  (wr_go),
    .o_strobe (wr_strb),
    .o_is32   (wr_is32)
  );

  ////////////////////////////////////////////////////////////////////////////
  // program bus drive; address passed unaligned, memory drops bit zero
  // the address holds its last value between transfers; only the read
  // and write qualifiers say whether the program bus carries anything
  // a fetch is always presented as a 32-bit read, and the instruction
  // boundaries inside the returned beat are found further up the core
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_prog_addr_bus <= '0;
      o_prog_rd       <= 1'b0;
      o_prog_wr       <= 1'b0;
      o_prog_is32     <= 1'b0;
    end else begin
      o_prog_rd <= fetch_go;
      o_prog_wr <= prog_wr_go;
      if (fetch_go) begin
        o_prog_addr_bus <= i_fetch_addr;
        o_prog_is32     <= 1'b1;
      end else if (prog_wr_go) begin
        o_prog_addr_bus <= i_wr_addr[PAW-1:0];
        o_prog_is32     <= wr_is32;
      end else begin
        o_prog_is32     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data read bus drive
  // independent of both program and write traffic, so a data read is
  // never stalled by this block; the address is held between reads to
  // keep the data read address bus quiet for power
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_data_rd_addr_bus <= '0;
      o_data_rd          <= 1'b0;
      o_data_rd_is32     <= 1'b0;
      o_data_rd_strobe   <= STRB_NONE;
    end else begin
      o_data_rd        <= i_rd_req;
      o_data_rd_is32   <= rd_is32;
      o_data_rd_strobe <= rd_strb;
      if (i_rd_req) begin
        o_data_rd_addr_bus <= i_rd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write bus drive, shared write data for both spaces
  // the shared write data bus loads for either kind of write, while the
  // data write address bus loads only for data space writes; program
  // write addresses travel on the program address bus instead
  // the byte strobes follow whichever write was granted this cycle
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_data_wr_addr_bus   <= '0;
      o_data_wr            <= 1'b0;
      o_data_wr_is32       <= 1'b0;
      o_wr_strobe          <= STRB_NONE;
      o_shared_wr_data_bus <= '0;
    end else begin
      o_data_wr      <= data_wr_go;
      o_data_wr_is32 <= data_wr_go && wr_is32;
      o_wr_strobe    <= wr_strb;
      if (data_wr_go) begin
        o_data_wr_addr_bus <= i_wr_addr;
      end
      if (wr_go) begin
        o_shared_wr_data_bus <= i_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read return, one cycle after the address phase
  // memory answers combinationally during the address phase, so the
  // return data is captured at the edge that ends that phase; a slower
  // memory would need a wait signal, which this interface does not have
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_fetch_data  <= '0;
      o_fetch_valid <= 1'b0;
      o_rd_data     <= '0;
      o_rd_valid    <= 1'b0;
    end else begin
      o_fetch_valid <= o_prog_rd;
      o_rd_valid    <= o_data_rd;
      if (o_prog_rd) begin
        o_fetch_data <= i_prog_rd_data_bus;
      end
      if (o_data_rd) begin
        o_rd_data <= i_data_rd_data_bus;
      end
    end
  end

endmodule : mbi_core_if
`default_nettype wire

// file: inc/mbi_pkg.sv
package mbi_pkg;
  // bus widths
  localparam int PAW = 22;  // program address width
  localparam int DAW = 32;  // data address width
  localparam int DW  = 32;  // data bus width
  localparam int WW  = 16;  // one addressable word

  // vector table in program space
  localparam int                  VEC_COUNT      = 32;
  localparam int                  VEC_WORDS      = 2;
  localparam int                  VEC_TABLE_SIZE = VEC_COUNT * VEC_WORDS;
  localparam logic [PAW-1:0]      VEC_BASE_DEF   = 22'h3fffc0;

  // access size codes
  typedef enum logic [1:0] {
    MBI_SZ_16 = 2'h0,
    MBI_SZ_32 = 2'h1,
    MBI_SZ_LO = 2'h2,
    MBI_SZ_HI = 2'h3
  } mbi_size_t;

  // byte strobe patterns
  localparam logic [1:0] STRB_NONE = 2'h0;
  localparam logic [1:0] STRB_LO   = 2'h1;
  localparam logic [1:0] STRB_HI   = 2'h2;

  // write arbiter states
  typedef enum logic [1:0] {
    MBI_WR_IDLE = 2'b01,
    MBI_WR_HOLD = 2'b10
  } mbi_wst_t;
endpackage : mbi_pkg

// file: rtl/mbi_strobe.sv
`timescale 1ns/1ps
`default_nettype none
module mbi_strobe
  import mbi_pkg::*;
(
  input  wire logic [1:0] i_size,
  input  wire logic       i_valid,
  output logic      [1:0] o_strobe,
  output logic            o_is32
);
  ////////////////////////////////////////////////////////////////////////////
  // byte lane decode for one bus
  always_comb begin
    o_strobe = STRB_NONE;
    o_is32   = 1'b0;
    if (i_valid) begin
      if (i_size == MBI_SZ_LO) begin
        o_strobe = STRB_LO;
      end else if (i_size == MBI_SZ_HI) begin
        o_strobe = STRB_HI;
      end else if (i_size == MBI_SZ_32) begin
        o_is32 = 1'b1;
      end
    end
  end
endmodule : mbi_strobe
`default_nettype wire

// file: tb/mbi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbi_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_prog_rd,
  input  wire logic        i_data_rd,
  input  wire logic        i_rd_is32,
  input  wire logic [21:0] i_prog_addr,
  input  wire logic [31:0] i_rd_addr,
  output logic      [31:0] o_prog_data,
  output logic      [31:0] o_rd_data
);
  logic [31:0] junk_r = 32'h0;
  // idle pattern changes every cycle
  always_ff @(posedge i_clk_sys) junk_r <= junk_r + 32'h1;
  // 32-bit reads drop address bit zero
  always_comb begin
    o_prog_data = i_prog_rd ? {10'h0, i_prog_addr[21:1], 1'b0} ^ 32'h3c5a96e1 : junk_r;
    o_rd_data = i_data_rd ? (i_rd_is32 ? {i_rd_addr[31:1], 1'b0} : i_rd_addr) ^ 32'h3c5a96e1
                          : ~junk_r;
  end
endmodule : mbi_mem_model
`default_nettype wire

// file: tb/mbi_core_if_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mbi_core_if_monitor
  import mbi_pkg::*;
#(parameter logic [PAW-1:0] VEC_BASE = VEC_BASE_DEF) (
  input wire logic i_clk_sys, i_reset, i_fetch_req, i_rd_req, i_wr_req, i_wr_prog,
  input wire logic o_wr_ready, o_prog_rd, o_prog_wr, o_prog_is32, o_data_rd,
  input wire logic o_data_rd_is32, o_data_wr, o_fetch_valid, o_data_wr_is32, o_fetch_ready,
  input wire logic [PAW-1:0] i_fetch_addr, o_prog_addr_bus, o_vec_addr,
  input wire logic [DW-1:0] i_rd_addr, i_wr_data, i_prog_rd_data_bus, o_fetch_data,
  input wire logic [DW-1:0] o_data_rd_addr_bus, o_shared_wr_data_bus,
  input wire logic [1:0] i_rd_size, o_data_rd_strobe, i_wr_size, o_wr_strobe,
  input wire logic [4:0] i_vec_num
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_prog_excl: assert property (!(o_prog_rd && o_prog_wr))
    else $error("program read and write together");
  a_wrbus_excl: assert property (!(o_prog_wr && o_data_wr))
    else $error("two writes on the write bus");
  a_fetch_issue: assert property (i_fetch_req |=> o_prog_rd && o_prog_is32
    && o_prog_addr_bus == $past(i_fetch_addr)) else $error("fetch address phase wrong");
  a_rd_issue: assert property (i_rd_req |=> o_data_rd
    && o_data_rd_addr_bus == $past(i_rd_addr)) else $error("read address phase wrong");
  a_rd_strobe: assert property (i_rd_req |=> o_data_rd_is32 == ($past(i_rd_size) == MBI_SZ_32)
    && o_data_rd_strobe == ($past(i_rd_size) == MBI_SZ_LO ? STRB_LO :
    $past(i_rd_size) == MBI_SZ_HI ? STRB_HI : STRB_NONE)) else $error("read qualifiers wrong");
  a_fetch_data: assert property (o_prog_rd |=> o_fetch_valid
    && o_fetch_data == $past(i_prog_rd_data_bus)) else $error("fetch data wrong");
  a_wr_refuse: assert property (i_wr_req && i_wr_prog && i_fetch_req |-> !o_wr_ready)
    else $error("program write taken beside fetch");
  a_wr_taken: assert property (o_wr_ready |=> (o_prog_wr ^ o_data_wr)
    && o_shared_wr_data_bus == $past(i_wr_data)) else $error("write phase wrong");
  a_all_concur: assert property (i_fetch_req && i_rd_req && i_wr_req && !i_wr_prog
    |=> o_prog_rd && o_data_rd && o_data_wr) else $error("disjoint buses not concurrent");
  a_dwr_qual: assert property (o_wr_ready && !i_wr_prog |=>
    o_data_wr_is32 == ($past(i_wr_size) == MBI_SZ_32)
    && o_wr_strobe == ($past(i_wr_size) == MBI_SZ_LO ? STRB_LO :
    $past(i_wr_size) == MBI_SZ_HI ? STRB_HI : STRB_NONE)) else $error("data write qualifiers wrong");
  a_pwr_qual: assert property (o_wr_ready && i_wr_prog |=>
    o_prog_is32 == ($past(i_wr_size) == MBI_SZ_32)) else $error("program write size wrong");
  a_fetch_ready: assert property (o_fetch_ready)
    else $error("fetch not ready");
  a_vec_addr: assert property (o_vec_addr == VEC_BASE + {i_vec_num, 1'b0})
    else $error("vector address wrong");
endmodule : mbi_core_if_monitor
bind mbi_core_if mbi_core_if_monitor #(.VEC_BASE(VEC_BASE)) i_mon (.*);
`default_nettype wire

// file: tb/mbi_core_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbi_core_if_tb
  import mbi_pkg::*;
;
  logic i_clk_sys = 0, i_reset = 1, i_fetch_req = 0, i_rd_req = 0, i_wr_req = 0, i_wr_prog = 0;
  logic [21:0] i_fetch_addr = 0;
  logic [31:0] i_rd_addr = 0, i_wr_addr = 0, i_wr_data = 0, r;
  logic [1:0] i_rd_size = 0, i_wr_size = 0;
  logic [4:0] i_vec_num = 0;
  wire [31:0] i_prog_rd_data_bus, i_data_rd_data_bus, o_fetch_data, o_rd_data;
  wire [31:0] o_data_rd_addr_bus, o_data_wr_addr_bus, o_shared_wr_data_bus;
  wire [21:0] o_vec_addr, o_prog_addr_bus;
  wire [1:0] o_data_rd_strobe, o_wr_strobe;
  wire o_fetch_ready, o_fetch_valid, o_rd_valid, o_wr_ready, o_prog_rd, o_prog_wr, o_prog_is32;
  wire o_data_rd, o_data_rd_is32, o_data_wr, o_data_wr_is32;
  logic [31:0] fq[$], rq[$];
  logic [64:0] wq[$];
  integer seed = 32'h334a5025, errors = 0, num_checks = 0, n;
  logic hold = 0;
  mbi_core_if i_dut (.*);
  mbi_mem_model i_mem (.i_clk_sys(i_clk_sys), .i_prog_rd(o_prog_rd), .i_data_rd(o_data_rd),
    .i_rd_is32(o_data_rd_is32), .i_prog_addr(o_prog_addr_bus), .i_rd_addr(o_data_rd_addr_bus),
    .o_prog_data(i_prog_rd_data_bus), .o_rd_data(i_data_rd_data_bus));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mv(input logic [31:0] a);
    return a ^ 32'h3c5a96e1;
  endfunction : mv
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // clock
  initial forever #4 i_clk_sys = ~i_clk_sys;
  // result watcher takes the oldest note
  always @(negedge i_clk_sys) if (!i_reset) begin
    if (o_fetch_valid === 1'b1) begin
      chk(fq.size() > 0 && o_fetch_data === fq[0], "fetch data");
      void'(fq.pop_front());
    end
    if (o_rd_valid === 1'b1) begin
      chk(rq.size() > 0 && o_rd_data === rq[0], "read data");
      void'(rq.pop_front());
    end
    if ((o_prog_wr | o_data_wr) === 1'b1) begin
      chk(wq.size() > 0 && {o_prog_wr, o_prog_wr ? {10'h0, o_prog_addr_bus} : o_data_wr_addr_bus,
        o_shared_wr_data_bus} === wq[0], "write");
      void'(wq.pop_front());
    end
  end
  // random driver notes each expected result
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #1 i_reset = 0;
    for (n = 0; n < 32; n++) begin
      i_vec_num = n[4:0];
      #1 chk(o_vec_addr === VEC_BASE_DEF + 22'(2 * n), "vector");
    end
    for (n = 0; n < 400 || hold; n++) begin
      @(posedge i_clk_sys);
      #1 r = $random(seed);
      if (!hold) begin
        {i_wr_req, i_wr_prog, i_wr_size} = r[3:0];
        i_wr_addr = $random(seed);
        i_wr_data = $random(seed);
      end
      {i_rd_req, i_rd_size} = r[7:5];
      i_fetch_req = r[4] & !hold;
      i_fetch_addr = r[31:10];
      i_rd_addr = $random(seed);
      #1 hold = i_wr_req && i_wr_prog && i_fetch_req;
      if (i_fetch_req) fq.push_back(mv({10'h0, i_fetch_addr[21:1], 1'b0}));
      if (i_rd_req) rq.push_back(mv(i_rd_size == 2'h1 ? {i_rd_addr[31:1], 1'b0} : i_rd_addr));
      chk(o_wr_ready === (i_wr_req && !hold), "write ready");
      if (i_wr_req && !hold) wq.push_back({i_wr_prog, i_wr_prog ? {10'h0, i_wr_addr[21:0]}
        : i_wr_addr, i_wr_data});
    end
    @(posedge i_clk_sys);
    #1 {i_fetch_req, i_rd_req, i_wr_req} = 3'h0;
    repeat (4) @(posedge i_clk_sys);
    chk(fq.size() + rq.size() + wq.size() == 0, "results missing");
    end_of_test();
  end
endmodule : mbi_core_if_tb
`default_nettype wire
